// [ldfs_chk.sv]
// checker for the line driver fault supervisor ports
`timescale 1ns/100ps
module ldfs_chk
	import ldfs_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic line_transceiver_enable,
	input wire logic line_driver_enable,
	input wire logic line_drive_in,
	input wire logic aux_out_enable,
	input wire logic aux_drive_in,
	input wire logic limit_sel_1,
	input wire logic limit_sel_0,
	input wire logic line_overcur,
	input wire logic sensor_supply_ok,
	input wire logic core_supply_ok,
	input wire logic logic_supply_ok,
	input wire logic sensor_below_warn,
	input wire logic sensor_below_scale,
	input wire logic line_hs_on,
	input wire logic line_ls_on,
	input wire logic aux_hs_on,
	input wire logic aux_ls_on,
	input wire logic line_receive_out,
	input wire logic rx_scaled_thresh,
	input wire logic [8:0] limit_ma,
	input wire logic line_fault_n_oe,
	input wire logic aux_fault_n_oe,
	input wire logic supply_warn_n_oe,
	input wire logic supply_uvlo_n_oe
);
	int up_r;
	int oc_r;
	// pins take three edges, so hold off until the pipe is refilled
	always_ff @(posedge clock) begin
		up_r <= rst ? 0 : (up_r < 8 ? up_r + 1 : up_r);
		oc_r <= (rst || !line_overcur) ? 0 : oc_r + 1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst || up_r < 8);
	a_line_off: assert property (!$past(line_transceiver_enable, 3) |->
		!line_hs_on && !line_ls_on && !line_receive_out) else $error("line on");
	a_drv_off: assert property ($past(line_transceiver_enable, 3) &&
		!$past(line_driver_enable, 3) |-> !line_hs_on && !line_ls_on)
		else $error("driver on");
	a_line_pol: assert property (line_hs_on || line_ls_on |->
		line_ls_on == $past(line_drive_in, 3) && !(line_hs_on && line_ls_on))
		else $error("line polarity");
	a_aux_pol: assert property (aux_hs_on || aux_ls_on |->
		$past(aux_out_enable, 3) && aux_ls_on == $past(aux_drive_in, 3))
		else $error("aux polarity");
	a_limit_map: assert property (limit_ma ==
		($past(limit_sel_1, 3) ? ($past(limit_sel_0, 3) ? 9'h17C : 9'h13C)
		: ($past(limit_sel_0, 3) ? 9'h0FC : 9'h07D))) else $error("limit");
	a_supply_cut: assert property (!$past(sensor_supply_ok, 3) ||
		!$past(core_supply_ok, 3) || !$past(logic_supply_ok, 3) |->
		!(line_hs_on || line_ls_on || aux_hs_on || aux_ls_on))
		else $error("driver on at low supply");
	a_uvlo_pin: assert property (supply_uvlo_n_oe ==
		(!$past(sensor_supply_ok, 3) || !$past(core_supply_ok, 3)))
		else $error("uvlo pin");
	a_warn_pin: assert property (supply_warn_n_oe ==
		($past(sensor_below_warn, 3) || !$past(core_supply_ok, 3)))
		else $error("warn pin");
	a_scale_pin: assert property (rx_scaled_thresh ==
		$past(sensor_below_scale, 3)) else $error("scaled threshold");
	a_blank_time: assert property (oc_r == 20010 |-> line_fault_n_oe)
		else $error("no fault after blanking");
	cover property ($rose(line_fault_n_oe));
	cover property ($rose(aux_fault_n_oe));
	cover property ($fell(supply_uvlo_n_oe));
endmodule
bind ldfs_top ldfs_chk u_chk (.*);

// [ldfs_line_load.sv]
// line wire seen by the controller: driven level or drifting
`timescale 1ns/100ps
module ldfs_line_load (
	input wire logic clock,
	input wire logic hs,
	input wire logic ls,
	output logic sense
);
	// undriven line has no pull, so it wanders rather than holding
	// an unknown start resolves to high, so one process owns the wire
	always_ff @(posedge clock) begin
		sense <= hs ? 1'h1 : (ls ? 1'h0 : (sense === 1'h1 ? 1'h0 : 1'h1));
	end
endmodule

// [ldfs_pkg.sv]
// types for the line driver control and fault supervisor
package ldfs_pkg;
	typedef enum logic [1:0] {
		LDFS_ST_OK = 2'b00,
		LDFS_ST_BLANK = 2'b01,
		LDFS_ST_FAULT = 2'b10,
		LDFS_ST_RETRY = 2'b11
	} ldfs_state_t;
endpackage

// [ldfs_regs.svh]
// constants for the line driver control and fault supervisor
`ifndef LDFS_REGS_SVH
`define LDFS_REGS_SVH
`define LDFS_CLK_HZ 40000000
`define LDFS_BLANK_US 500
`define LDFS_RETRY_MS 50
`define LDFS_BLANK_CYC ((`LDFS_CLK_HZ / 1000000) * `LDFS_BLANK_US)
`define LDFS_RETRY_CYC ((`LDFS_CLK_HZ / 1000) * `LDFS_RETRY_MS)
`define LDFS_CNT_W 22
// current limit codes, value in mA
`define LDFS_LIM_LL 9'h07D
`define LDFS_LIM_LH 9'h0FC
`define LDFS_LIM_HL 9'h13C
`define LDFS_LIM_HH 9'h17C
// avalon register offsets (word index)
`define LDFS_REG_CTRL 2'h0
`define LDFS_REG_STAT 2'h1
`define LDFS_REG_LIMIT 2'h2
`endif

// [ldfs_top.sv]
// pin-controlled line driver control and fault supervisor
// Overview of operation
// - transceiver enable low disables driver and receiver
// - driver enable low keeps both switches off
// - line output is inverse of drive input
// - aux enable low turns aux switches off
// - aux output is inverse of aux input
// - limit selects decode to shared current threshold
// - overcurrent past blanking enters fault mode
// - retry mode: blanking expiry disables, asserts fault
// - retry mode: reenable after 50 ms, repeat
// - retry mode: overload gone, release within 50ms
// - no retry: fault after 500us, stay limited
// - no retry: thermal disables, reenables on cool
// - receive out inverse of line, low disabled
// - scaled receiver thresholds below 18 V
// - drivers off until all supplies good
// - warn low while supply below 16.5 V
// - uvlo low, drivers disabled; receivers disabled only when sensor supply is low
// - warn and uvlo indicators held low until core supply good
// - aux fault on overload or thermal shutdown
`timescale 1ns/100ps
`include "ldfs_regs.svh"

// per-driver overcurrent / thermal fault tracker
module ldfs_drv_fault
	import ldfs_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic retry_en,
	input wire logic overcur,
	input wire logic overtemp,
	output logic drv_allow,
	output logic fault
);
	ldfs_state_t st_r;
	logic [`LDFS_CNT_W-1:0] cnt_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= LDFS_ST_OK;
			cnt_r <= '0;
		end else begin
			case (st_r)
				LDFS_ST_OK: begin
					cnt_r <= '0;
					if (overcur)
						st_r <= LDFS_ST_BLANK;
				end
				LDFS_ST_BLANK: begin
					if (!overcur) begin
						st_r <= LDFS_ST_OK;
					end else if (cnt_r == `LDFS_CNT_W'(`LDFS_BLANK_CYC - 1)) begin
						st_r <= LDFS_ST_FAULT;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				LDFS_ST_FAULT: begin
					// retry mode: off for the retry time, then try again
					if (retry_en) begin
						if (cnt_r == `LDFS_CNT_W'(`LDFS_RETRY_CYC - 1)) begin
							st_r <= LDFS_ST_RETRY;
							cnt_r <= '0;
						end else begin
							cnt_r <= cnt_r + 1'b1;
						end
					end else if (!overcur) begin
						st_r <= LDFS_ST_OK;
					end
				end
				LDFS_ST_RETRY: begin
					// fault stays asserted while the driver is tried again
					if (!overcur)
						st_r <= LDFS_ST_OK;
					else if (cnt_r == `LDFS_CNT_W'(`LDFS_BLANK_CYC - 1)) begin
						st_r <= LDFS_ST_FAULT;
						cnt_r <= '0;
					end else
						cnt_r <= cnt_r + 1'b1;
				end
				default: begin
					st_r <= LDFS_ST_OK;
					cnt_r <= '0;
				end
			endcase
		end
	end

	// no-retry overcurrent only limits; thermal always cuts the driver
	assign drv_allow = !overtemp &&
		!(retry_en && st_r == LDFS_ST_FAULT);
	assign fault = overtemp || st_r == LDFS_ST_FAULT ||
		st_r == LDFS_ST_RETRY;
endmodule

module ldfs_top
	import ldfs_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic line_transceiver_enable,
	input wire logic line_driver_enable,
	input wire logic line_drive_in,
	input wire logic aux_out_enable,
	input wire logic aux_drive_in,
	input wire logic limit_sel_1,
	input wire logic limit_sel_0,
	input wire logic retry_enable,
	input wire logic line_sense_in,
	input wire logic aux_in_pin,
	input wire logic line_overcur,
	input wire logic aux_overcur,
	input wire logic line_overtemp,
	input wire logic aux_overtemp,
	input wire logic sensor_supply_ok,
	input wire logic core_supply_ok,
	input wire logic logic_supply_ok,
	input wire logic sensor_below_warn,
	input wire logic sensor_below_scale,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic line_hs_on,
	output logic line_ls_on,
	output logic aux_hs_on,
	output logic aux_ls_on,
	output logic line_receive_out,
	output logic aux_receive_out,
	output logic rx_scaled_thresh,
	output logic [8:0] limit_ma,
	output logic line_fault_n_oe,
	output logic aux_fault_n_oe,
	output logic supply_warn_n_oe,
	output logic supply_uvlo_n_oe
);
	import ldfs_pkg::*;

	localparam int NS = 18;
	logic [NS-1:0] s1_r, s2_r;
	logic line_en, drv_en, line_tx, aux_en, aux_tx, sel1, sel0, retry;
	logic line_rx, aux_rx, l_oc, a_oc, l_ot, a_ot, sup_ok, core_ok, lg_ok;
	logic warn, scale;
	logic line_allow, aux_allow, line_flt, aux_flt, powered;
	logic sw_force_off_r;

	// two-stage synchronisers on every pin and comparator input
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= {line_transceiver_enable, line_driver_enable,
				line_drive_in, aux_out_enable, aux_drive_in, limit_sel_1,
				limit_sel_0, retry_enable, line_sense_in, aux_in_pin,
				line_overcur, aux_overcur, line_overtemp, aux_overtemp,
				sensor_supply_ok, core_supply_ok, logic_supply_ok,
				sensor_below_warn};
			s2_r <= s1_r;
		end
	end
	assign {line_en, drv_en, line_tx, aux_en, aux_tx, sel1, sel0, retry,
		line_rx, aux_rx, l_oc, a_oc, l_ot, a_ot, sup_ok, core_ok, lg_ok,
		warn} = s2_r;

	// scale threshold input synchronised on its own
	logic sc1_r, sc2_r;
	always_ff @(posedge clock) begin
		if (rst) begin
			sc1_r <= 1'b0;
			sc2_r <= 1'b0;
		end else begin
			sc1_r <= sensor_below_scale;
			sc2_r <= sc1_r;
		end
	end
	assign scale = sc2_r;

	ldfs_drv_fault u_line_fault (
		.clock(clock),
		.rst(rst),
		.retry_en(retry),
		.overcur(l_oc),
		.overtemp(l_ot),
		.drv_allow(line_allow),
		.fault(line_flt)
	);

	ldfs_drv_fault u_aux_fault (
		.clock(clock),
		.rst(rst),
		.retry_en(retry),
		.overcur(a_oc),
		.overtemp(a_ot),
		.drv_allow(aux_allow),
		.fault(aux_flt)
	);

	// sensor supply ok also covers the uvlo level
	assign powered = sup_ok && core_ok && lg_ok && !sw_force_off_r;

	// software off switch, default clear so pins alone run the block
	always_ff @(posedge clock) begin
		if (rst)
			sw_force_off_r <= 1'b0;
		else if (avs_write && avs_address == `LDFS_REG_CTRL)
			sw_force_off_r <= avs_writedata[0];
	end

	// driver switches, all registered
	always_ff @(posedge clock) begin
		if (rst) begin
			line_hs_on <= 1'b0;
			line_ls_on <= 1'b0;
			aux_hs_on <= 1'b0;
			aux_ls_on <= 1'b0;
		end else begin
			line_hs_on <= powered && line_en && drv_en && line_allow &&
				!line_tx;
			line_ls_on <= powered && line_en && drv_en && line_allow &&
				line_tx;
			aux_hs_on <= powered && aux_en && aux_allow && !aux_tx;
			aux_ls_on <= powered && aux_en && aux_allow && aux_tx;
		end
	end

	// receivers and limit decode
	always_ff @(posedge clock) begin
		if (rst) begin
			line_receive_out <= 1'b0;
			aux_receive_out <= 1'b0;
			rx_scaled_thresh <= 1'b0;
			limit_ma <= `LDFS_LIM_LL;
		end else begin
			line_receive_out <= line_en && sup_ok && !line_rx;
			aux_receive_out <= sup_ok && !aux_rx;
			rx_scaled_thresh <= scale;
			case ({sel1, sel0})
				2'b00: limit_ma <= `LDFS_LIM_LL;
				2'b01: limit_ma <= `LDFS_LIM_LH;
				2'b10: limit_ma <= `LDFS_LIM_HL;
				default: limit_ma <= `LDFS_LIM_HH;
			endcase
		end
	end

	// open-drain indicators: enable high pulls the pin low
	always_ff @(posedge clock) begin
		if (rst) begin
			line_fault_n_oe <= 1'b0;
			aux_fault_n_oe <= 1'b0;
			supply_warn_n_oe <= 1'b1;
			supply_uvlo_n_oe <= 1'b1;
		end else begin
			line_fault_n_oe <= line_flt;
			aux_fault_n_oe <= aux_flt;
			// independent of logic supply; low while core not good
			supply_warn_n_oe <= !core_ok || warn;
			supply_uvlo_n_oe <= !core_ok || !sup_ok;
		end
	end

	// avalon slave: fixed one wait cycle on every access
	logic busy_r;
	always_ff @(posedge clock) begin
		if (rst)
			busy_r <= 1'b0;
		else
			busy_r <= (avs_read || avs_write) && !busy_r;
	end
	always_ff @(posedge clock) begin
		if (rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !((avs_read || avs_write) && !busy_r);
	end
	always_ff @(posedge clock) begin
		if (rst)
			avs_readdata <= 32'h0;
		else if (avs_read && !busy_r) begin
			case (avs_address)
				`LDFS_REG_CTRL: avs_readdata <= {31'h0, sw_force_off_r};
				`LDFS_REG_STAT: avs_readdata <= {24'h0, warn, !sup_ok,
					aux_flt, line_flt, a_ot, l_ot, a_oc, l_oc};
				`LDFS_REG_LIMIT: avs_readdata <= {23'h0, limit_ma};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end
endmodule

// [ldfs_top_bench.sv]
// self-checking bench for the line driver fault supervisor
`timescale 1ns/100ps
`include "ldfs_regs.svh"
module ldfs_top_bench;
	import ldfs_pkg::*;
	logic clock, rst, line_transceiver_enable, line_driver_enable;
	logic line_drive_in, aux_out_enable, aux_drive_in, limit_sel_1;
	logic limit_sel_0, retry_enable, line_sense_in, aux_in_pin;
	logic line_overcur, aux_overcur, line_overtemp, aux_overtemp;
	logic sensor_supply_ok, core_supply_ok, logic_supply_ok;
	logic sensor_below_warn, sensor_below_scale, avs_read, avs_write;
	logic [1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic avs_waitrequest, line_hs_on, line_ls_on, aux_hs_on, aux_ls_on;
	logic line_receive_out, aux_receive_out, rx_scaled_thresh;
	logic [8:0] limit_ma;
	logic line_fault_n_oe, aux_fault_n_oe, supply_warn_n_oe, supply_uvlo_n_oe;
	logic [8:0] lim [4] = '{9'h07D, 9'h0FC, 9'h13C, 9'h17C};
	int failures, comparisons, cyc;
	ldfs_top DUT (.*);
	ldfs_line_load u_load (.clock(clock), .hs(line_hs_on), .ls(line_ls_on),
		.sense(line_sense_in));
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("Error at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	task bus(input logic w, input logic [1:0] a, input logic [31:0] d);
		avs_read <= ~w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge clock);
	endtask
	// ceiling allows two blanking waits plus margin
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			end_sim;
		end
	end
	initial begin
		rst <= 1'h1;
		{line_transceiver_enable, line_driver_enable, line_drive_in} <= 3'h0;
		{aux_out_enable, aux_drive_in, limit_sel_1, limit_sel_0} <= 4'h0;
		{retry_enable, aux_in_pin, line_overcur, aux_overcur} <= 4'h0;
		{line_overtemp, aux_overtemp, sensor_below_warn} <= 3'h0;
		{sensor_below_scale, avs_read, avs_write} <= 3'h0;
		{sensor_supply_ok, core_supply_ok, logic_supply_ok} <= 3'h7;
		avs_address <= 2'h0;
		avs_writedata <= 32'h0;
		wt(10);
		rst <= 1'h0;
		wt(2);
		for (int i = 0; i < 8; i++) begin
			{line_transceiver_enable, line_driver_enable, line_drive_in} <= i[2:0];
			wt(8);
			chk({line_hs_on, line_ls_on}, i > 5 ? 2'h2 >> i[0] : 2'h0);
			if (i < 4 || i > 5) chk(line_receive_out, i == 7);
		end
		for (int i = 0; i < 4; i++) begin
			{aux_out_enable, aux_drive_in, limit_sel_1, limit_sel_0} <= {i[1:0], i[1:0]};
			aux_in_pin <= i[0];
			wt(8);
			chk({aux_hs_on, aux_ls_on}, i[1] ? 2'h2 >> i[0] : 2'h0);
			chk(aux_receive_out, !i[0]);
			chk(limit_ma, lim[i]);
		end
		{line_transceiver_enable, line_driver_enable, line_drive_in} <= 3'h6;
		{aux_drive_in, aux_in_pin} <= 2'h0;
		for (int i = 0; i < 3; i++) begin
			{sensor_supply_ok, core_supply_ok, logic_supply_ok} <= ~(3'h4 >> i);
			wt(8);
			chk({line_hs_on, aux_hs_on}, 2'h0);
			chk({supply_uvlo_n_oe, aux_receive_out}, {i < 2, i != 0});
		end
		{sensor_supply_ok, core_supply_ok, logic_supply_ok} <= 3'h7;
		{sensor_below_warn, sensor_below_scale} <= 2'h3;
		wt(8);
		chk({supply_warn_n_oe, rx_scaled_thresh, line_hs_on}, 3'h7);
		$display("pin tests done");
		bus(1'h1, `LDFS_REG_CTRL, 32'h1);
		wt(8);
		chk(line_hs_on, 1'h0);
		bus(1'h0, `LDFS_REG_CTRL, 32'h0);
		chk(rd, 32'h1);
		bus(1'h1, 2'h3, 32'hFFFF);
		bus(1'h0, 2'h3, 32'h0);
		chk(rd, 32'h0);
		bus(1'h1, `LDFS_REG_CTRL, 32'h0);
		bus(1'h0, `LDFS_REG_LIMIT, 32'h0);
		chk(rd, 32'h17C);
		$display("bus tests done");
		{sensor_below_warn, sensor_below_scale, line_overcur} <= 3'h1;
		wt(`LDFS_BLANK_CYC - 10);
		chk({line_fault_n_oe, line_hs_on}, 2'h1);
		wt(20);
		chk({line_fault_n_oe, line_hs_on}, 2'h3);
		bus(1'h0, `LDFS_REG_STAT, 32'h0);
		chk(rd[4], 1'h1);
		line_overcur <= 1'h0;
		line_overtemp <= 1'h1;
		wt(8);
		chk({line_fault_n_oe, line_hs_on}, 2'h2);
		line_overtemp <= 1'h0;
		wt(8);
		chk({line_fault_n_oe, line_hs_on}, 2'h1);
		{retry_enable, aux_overcur} <= 2'h3;
		wt(`LDFS_BLANK_CYC + 20);
		chk({aux_fault_n_oe, aux_hs_on, aux_ls_on}, 3'h4);
		aux_overcur <= 1'h0;
		wt(8);
		chk(aux_fault_n_oe, 1'h1);
		$display("fault tests done");
		end_sim;
	end
endmodule
